// [hdl/annunciator_defs.svh]
// timing and layout constants for the cabinet alarm annunciator
// assumes a 100 MHz system clock
`ifndef ANNUNCIATOR_DEFS_SVH
`define ANNUNCIATOR_DEFS_SVH

`define CLK_PERIOD_NS      10
`define TICK_MS            100
`define TICK_CYCLES_DEF    ((`TICK_MS * 1000000) / `CLK_PERIOD_NS)
`define QUALIFY_S          10
`define QUALIFY_TICKS      ((`QUALIFY_S * 1000) / `TICK_MS)
`define STEADY_S           30
`define STEADY_TICKS       ((`STEADY_S * 1000) / `TICK_MS)
`define BEEP_PERIOD_S      10
`define BEEP_PERIOD_TICKS  ((`BEEP_PERIOD_S * 1000) / `TICK_MS)
`define BEEP_LEN_TICKS     2
`define SLOW_BLINK_TICKS   5
`define FAST_BLINK_TICKS   1
`define FAULT_COUNT        5
`define FAULT_LOW          0
`define FAULT_HIGH         1
`define FAULT_MOTOR        2
`define FAULT_UV           3
`define FAULT_POWER        4
`define BAR_WIDTH          8

`endif

// [hdl/annunciator_pkg.sv]
// types shared by the cabinet alarm annunciator
// assumes annunciator_defs.svh for sizes
`include "annunciator_defs.svh"

package annunciator_pkg;

   typedef struct packed {
      logic airflowLow;
      logic airflowHigh;
      logic motorStalled;
      logic uvLampWorn;
   } fault_in_type;

   typedef struct packed {
      logic blowerOn;
      logic lightOn;
      logic uvOn;
      logic windowClosed;
      logic uvOverride;
   } command_type;

   typedef struct packed {
      logic                    alarmRed;
      logic                    blowerGreen;
      logic                    blowerRed;
      logic                    lightBlue;
      logic                    uvYellow;
      logic [`BAR_WIDTH-1:0]   barRed;
      logic [`BAR_WIDTH-1:0]   barAll;
   } led_type;

   typedef enum logic [1:0] {
      BUZ_IDLE   = 2'b00,
      BUZ_STEADY = 2'b01,
      BUZ_BEEP   = 2'b10
   } buzz_state_type;

endpackage : annunciator_pkg

// [hdl/fault_qualifier.sv]
// one fault qualifier: a condition must hold for the qualify time before it is passed on
// assumes the slow tick pulse from the annunciator timebase
`timescale 1ns/10ps
`default_nettype none

`include "annunciator_defs.svh"

module fault_qualifier (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // timing
   input  wire logic tick,
   // condition
   input  wire logic condition,
   output var  logic qualified
);

   localparam int QW = $clog2(`QUALIFY_TICKS + 1);

   logic [QW-1:0] count_reg;
   logic [QW-1:0] count_next;
   wire           reached = (count_reg == QW'(`QUALIFY_TICKS));

   // a dropout restarts the count
   assign count_next = !condition ? '0 :
                       (tick && !reached) ? count_reg + QW'(1) : count_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) count_reg <= '0;
      else count_reg <= count_next;
   end

   assign qualified = reached && condition;

   chk_dropout_clears: assert property (@(posedge clk) disable iff (!rst_n)
      !condition |=> (count_reg == '0))
      else $error("qualifier count not cleared on dropout");

   chk_no_early_pass: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(qualified) |-> $past(tick) && $past(count_reg) == QW'(`QUALIFY_TICKS - 1))
      else $error("qualified before full time");

endmodule // fault_qualifier

`default_nettype wire

// [hdl/cabinet_alarm_annunciator.sv]
// cabinet alarm annunciator: fault qualification, buzzer cadence and indicator LEDs
// assumes keypad and sensor inputs synchronous to clk; LEDs and buzzer driven directly
`timescale 1ns/10ps
`default_nettype none

`include "annunciator_defs.svh"

// Notes on behaviour
// - a fault is annunciated only after holding for at least ten seconds without a break.
// - once annunciated the buzzer sounds steadily for thirty seconds, then beeps once each ten seconds.
// - an annunciated error stays latched after its cause has gone until it is cleared.
// - turning the blower off and on again, or a power cycle, clears latched errors.
// - after a power interruption the red alarm light blinks until any key is pressed.
// - a worn UV lamp blinks the UV key light fast with the red alarm, until the run time is cleared.
// - low airflow lights the leftmost red bar segment and the red alarm.
// - high airflow lights the rightmost red bar segment and the red alarm.
// - after new firmware is loaded every bar segment blinks until any key is pressed or the blower is cycled.
// - lost motor speed pulses blink the red blower key light and assert the red alarm.
// - green, blue and yellow key lights follow blower, light and UV commands.
// - after reset all indications and outputs start from their power-up state.
// - the UV lamp is allowed on only with the window closed, unless the service override is set.
module cabinet_alarm_annunciator
   import annunciator_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES_DEF
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // sensors and events
   input  wire annunciator_pkg::fault_in_type faults,
   input  wire logic                         powerRestored,
   input  wire logic                         firmwareLoaded,
   input  wire logic                         uvRuntimeClear,
   input  wire logic                         anyKey,
   // commands
   input  wire annunciator_pkg::command_type commands,
   // operator outputs
   output var  annunciator_pkg::led_type     leds,
   output var  logic                         buzzer,
   output var  logic                         uvLampEnable
);
   import annunciator_pkg::*;

   // ------------------------------------------------------------
   // timebase
   // ------------------------------------------------------------
   logic [31:0] divCount_reg;
   wire         tick = (divCount_reg == 32'(TICK_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (!rst_n) divCount_reg <= 32'h0000_0000;
      else if (tick) divCount_reg <= 32'h0000_0000;
      else divCount_reg <= divCount_reg + 32'h0000_0001;
   end

   logic [3:0] blinkCount_reg;
   logic       slowBlink_reg;
   logic       fastBlink_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blinkCount_reg <= 4'h0;
         slowBlink_reg  <= 1'b0;
         fastBlink_reg  <= 1'b0;
      end else if (tick) begin
         fastBlink_reg  <= ~fastBlink_reg;
         blinkCount_reg <= (blinkCount_reg == 4'(`SLOW_BLINK_TICKS - 1)) ? 4'h0
                           : blinkCount_reg + 4'h1;
         if (blinkCount_reg == 4'(`SLOW_BLINK_TICKS - 1)) slowBlink_reg <= ~slowBlink_reg;
      end
   end

   // ------------------------------------------------------------
   // fault qualification
   // ------------------------------------------------------------
   logic [`FAULT_COUNT-1:0] rawFault;
   logic [`FAULT_COUNT-1:0] qualFault;

   assign rawFault[`FAULT_LOW]   = faults.airflowLow;
   assign rawFault[`FAULT_HIGH]  = faults.airflowHigh;
   assign rawFault[`FAULT_MOTOR] = faults.motorStalled;
   assign rawFault[`FAULT_UV]    = faults.uvLampWorn;
   assign rawFault[`FAULT_POWER] = 1'b0;
   assign qualFault[`FAULT_POWER] = 1'b0;

   genvar g;
   generate
      for (g = 0; g < `FAULT_POWER; g++) begin : gQual
         fault_qualifier uQual (
            .clk       (clk),
            .rst_n     (rst_n),
            .tick      (tick),
            .condition (rawFault[g]),
            .qualified (qualFault[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // latched errors
   // ------------------------------------------------------------
   logic                    blowerOnPrev_reg;
   wire                     blowerCycle = commands.blowerOn && !blowerOnPrev_reg;
   logic [`FAULT_COUNT-1:0] latched_reg;
   logic [`FAULT_COUNT-1:0] latched_next;
   logic [`FAULT_COUNT-1:0] clearMask;

   always_comb begin
      clearMask = {`FAULT_COUNT{blowerCycle}};
      clearMask[`FAULT_UV]    = blowerCycle || uvRuntimeClear;
      clearMask[`FAULT_POWER] = anyKey;
   end

   // a new event wins over a clear in the same cycle
   always_comb begin
      latched_next = (latched_reg & ~clearMask) | qualFault;
      latched_next[`FAULT_POWER] = powerRestored
                                   || (latched_reg[`FAULT_POWER] && !anyKey);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         latched_reg      <= '0;
         blowerOnPrev_reg <= 1'b0;
      end else begin
         latched_reg      <= latched_next;
         blowerOnPrev_reg <= commands.blowerOn;
      end
   end

   logic fwAck_reg;
   always_ff @(posedge clk) begin
      if (!rst_n) fwAck_reg <= 1'b0;
      else if (firmwareLoaded) fwAck_reg <= 1'b1;
      else if (anyKey || blowerCycle) fwAck_reg <= 1'b0;
   end

   // ------------------------------------------------------------
   // buzzer cadence
   // ------------------------------------------------------------
   wire [`FAULT_COUNT-1:0] newAlarm = qualFault & ~latched_reg;
   wire                    anyAudible = |latched_reg[`FAULT_UV:0];
   buzz_state_type         buzz_reg;
   buzz_state_type         buzz_next;
   logic [8:0]             buzzTicks_reg;
   logic [8:0]             buzzTicks_next;

   always_comb begin
      buzz_next      = buzz_reg;
      buzzTicks_next = tick ? buzzTicks_reg + 9'h001 : buzzTicks_reg;
      unique case (buzz_reg)
         BUZ_IDLE: begin
            buzzTicks_next = 9'h000;
            if (|newAlarm) buzz_next = BUZ_STEADY;
         end
         BUZ_STEADY: begin
            if (!anyAudible) buzz_next = BUZ_IDLE;
            else if (tick && buzzTicks_reg == 9'(`STEADY_TICKS - 1)) begin
               buzz_next      = BUZ_BEEP;
               buzzTicks_next = 9'h000;
            end
         end
         BUZ_BEEP: begin
            if (!anyAudible) buzz_next = BUZ_IDLE;
            else if (|newAlarm) begin
               buzz_next      = BUZ_STEADY;
               buzzTicks_next = 9'h000;
            end else if (tick && buzzTicks_reg == 9'(`BEEP_PERIOD_TICKS - 1))
               buzzTicks_next = 9'h000;
         end
         default: buzz_next = BUZ_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         buzz_reg      <= BUZ_IDLE;
         buzzTicks_reg <= 9'h000;
      end else begin
         buzz_reg      <= buzz_next;
         buzzTicks_reg <= buzzTicks_next;
      end
   end

   wire buzzOn = (buzz_reg == BUZ_STEADY)
                 || (buzz_reg == BUZ_BEEP && buzzTicks_reg < 9'(`BEEP_LEN_TICKS));

   // ------------------------------------------------------------
   // indicator drive
   // ------------------------------------------------------------
   wire uvAllowed = commands.windowClosed || commands.uvOverride;
   led_type ledsNext;

   always_comb begin
      ledsNext             = '0;
      ledsNext.blowerGreen = commands.blowerOn;
      ledsNext.lightBlue   = commands.lightOn;
      ledsNext.uvYellow    = commands.uvOn && !latched_reg[`FAULT_UV];
      if (latched_reg[`FAULT_UV]) ledsNext.uvYellow = fastBlink_reg;
      ledsNext.blowerRed   = latched_reg[`FAULT_MOTOR] && slowBlink_reg;
      ledsNext.barRed[`BAR_WIDTH-1] = latched_reg[`FAULT_LOW];
      ledsNext.barRed[0]            = latched_reg[`FAULT_HIGH];
      ledsNext.barAll = {`BAR_WIDTH{fwAck_reg && slowBlink_reg}};
      ledsNext.alarmRed = |latched_reg[`FAULT_UV:0]
                          || (latched_reg[`FAULT_POWER] && slowBlink_reg);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         leds         <= '0;
         buzzer       <= 1'b0;
         uvLampEnable <= 1'b0;
      end else begin
         leds         <= ledsNext;
         buzzer       <= buzzOn;
         uvLampEnable <= commands.uvOn && uvAllowed;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_steady_done;
      (buzz_reg == BUZ_STEADY) ##1 (buzz_reg == BUZ_BEEP);
   endsequence

   chk_uv_interlock: assert property (@(posedge clk) disable iff (!rst_n)
      uvLampEnable |-> $past(uvAllowed))
      else $error("uv lamp enabled with window open");

   chk_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
      (latched_reg[`FAULT_LOW] && !blowerCycle) |=> latched_reg[`FAULT_LOW])
      else $error("latched fault dropped without clear");

   chk_blower_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (blowerCycle && qualFault == '0) |=> latched_reg[`FAULT_UV:0] == '0)
      else $error("blower cycle did not clear errors");

   chk_power_key: assert property (@(posedge clk) disable iff (!rst_n)
      (anyKey && !powerRestored) |=> !latched_reg[`FAULT_POWER])
      else $error("power indication not cleared by key");

   chk_steady_length: assert property (@(posedge clk) disable iff (!rst_n)
      s_steady_done |-> $past(buzzTicks_reg, 1) == 9'(`STEADY_TICKS - 1))
      else $error("steady buzz left early");

   chk_buzz_start: assert property (@(posedge clk) disable iff (!rst_n)
      (buzz_reg == BUZ_IDLE && |newAlarm) |=> ##1 buzzer)
      else $error("buzzer not started on new alarm");

   chk_low_led: assert property (@(posedge clk) disable iff (!rst_n)
      latched_reg[`FAULT_LOW] |=> leds.barRed[`BAR_WIDTH-1] && leds.alarmRed)
      else $error("low airflow indication missing");

   chk_high_led: assert property (@(posedge clk) disable iff (!rst_n)
      latched_reg[`FAULT_HIGH] |=> leds.barRed[0] && leds.alarmRed)
      else $error("high airflow indication missing");

   chk_green_follow: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 leds.blowerGreen == $past(commands.blowerOn))
      else $error("blower green light wrong");

   chk_reset_quiet: assert property (@(posedge clk)
      !rst_n |=> !buzzer && leds == '0 && !uvLampEnable)
      else $error("outputs not cleared by reset");

   chk_motor_led: assert property (@(posedge clk) disable iff (!rst_n)
      latched_reg[`FAULT_MOTOR] |=> leds.alarmRed && leds.blowerRed == $past(slowBlink_reg))
      else $error("motor stall indication missing");

   chk_uv_worn_led: assert property (@(posedge clk) disable iff (!rst_n)
      latched_reg[`FAULT_UV] |=> leds.alarmRed && leds.uvYellow == $past(fastBlink_reg))
      else $error("uv lamp worn indication missing");

   chk_uv_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (uvRuntimeClear && !qualFault[`FAULT_UV]) |=> !latched_reg[`FAULT_UV])
      else $error("uv worn latch not cleared by run time clear");

   chk_power_blink: assert property (@(posedge clk) disable iff (!rst_n)
      (latched_reg[`FAULT_POWER] && latched_reg[`FAULT_UV:0] == '0)
         |=> leds.alarmRed == $past(slowBlink_reg))
      else $error("power indication not blinking");

   chk_fw_bar: assert property (@(posedge clk) disable iff (!rst_n)
      fwAck_reg |=> leds.barAll == {`BAR_WIDTH{$past(slowBlink_reg)}})
      else $error("firmware acknowledge bar wrong");

   chk_fw_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (anyKey && !firmwareLoaded) |=> !fwAck_reg)
      else $error("firmware acknowledge not cleared by key");

   chk_buzz_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      (!anyAudible && newAlarm == '0) |=> ##1 !buzzer)
      else $error("buzzer sounding with no annunciated fault");

   chk_beep_short: assert property (@(posedge clk) disable iff (!rst_n)
      (buzz_reg == BUZ_BEEP && buzzTicks_reg >= 9'(`BEEP_LEN_TICKS)) |=> !buzzer)
      else $error("beep longer than its length");

   chk_blue_follow: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 leds.lightBlue == $past(commands.lightOn))
      else $error("light blue indicator wrong");

endmodule // cabinet_alarm_annunciator

`default_nettype wire

// [verification/operator_panel_model.sv]
// operator panel model: keypad press pulses and a counter of buzzer-on cycles
// assumes all signals synchronous to clk; released key line rests low
`timescale 1ns/10ps
`default_nettype none

module operator_panel_model (
   // clock
   input  wire logic clk,
   // bench control
   input  wire logic pressReq,
   input  wire logic countClear,
   // annunciator side
   input  wire logic buzzer,
   output var  logic anyKey,
   output var  int   buzzCycles
);
   // one key pulse per request cycle
   always @(posedge clk) begin
      anyKey <= pressReq;
      if (countClear) begin
         buzzCycles <= 0;
      end else if (buzzer === 1'b1) begin
         buzzCycles <= buzzCycles + 1;
      end
   end
endmodule // operator_panel_model

`default_nettype wire

// [verification/test_cabinet_alarm_annunciator.sv]
// testbench for the cabinet alarm annunciator
// assumes a shortened tick of 4 cycles; panel model supplies key presses
`timescale 1ns/10ps
`default_nettype none
`include "annunciator_defs.svh"

module test_cabinet_alarm_annunciator;
   import annunciator_pkg::*;
   localparam int TICKC = 4;
   localparam int QUAL = `QUALIFY_TICKS * TICKC;
   localparam int STEADY = `STEADY_TICKS * TICKC;
   localparam int PERIOD = `BEEP_PERIOD_TICKS * TICKC;
   localparam int BEEP = `BEEP_LEN_TICKS * TICKC;
   logic         clk, rst_n, powerRestored, firmwareLoaded, uvRuntimeClear;
   logic         pressReq, countClear, anyKey, buzzer, uvLampEnable;
   fault_in_type faults;
   command_type  commands;
   led_type      leds;
   int           buzzCycles, failures, n_compared, cycles, ones, n;
   logic [31:0]  rng;

   cabinet_alarm_annunciator #(.TICK_CYCLES(TICKC)) cabinet_alarm_annunciator_inst (
      .clk(clk), .rst_n(rst_n), .faults(faults), .powerRestored(powerRestored),
      .firmwareLoaded(firmwareLoaded), .uvRuntimeClear(uvRuntimeClear), .anyKey(anyKey),
      .commands(commands), .leds(leds), .buzzer(buzzer), .uvLampEnable(uvLampEnable));
   operator_panel_model operator_panel_model_inst (
      .clk(clk), .pressReq(pressReq), .countClear(countClear), .buzzer(buzzer),
      .anyKey(anyKey), .buzzCycles(buzzCycles));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      logic [31:0] x;
      x = s;
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   function automatic logic expUv(input command_type c);
      return c.uvOn & (c.windowClosed | c.uvOverride);
   endfunction
   function automatic logic pickBit(input int sel);
      case (sel)
         0: return leds.alarmRed;
         1: return leds.blowerRed;
         2: return leds.uvYellow;
         default: return leds.barAll[0];
      endcase
   endfunction
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic checkBit(input logic got, input logic exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic checkCount(input int got, input int exp, input string msg);
      n_compared++;
      if (got != exp) begin
         failures++;
         $display("wrong value at %0t: %s got %0d want %0d", $time, msg, got, exp);
      end
   endtask
   // a blinking light shows both levels over a window of several ticks
   task automatic blinkCount(input int sel);
      ones = 0;
      repeat (60) begin
         step(1);
         if (pickBit(sel) === 1'b1) ones++;
      end
   endtask
   task automatic clearAll();
      commands.blowerOn = 1'b1;
      step(2);
      commands.blowerOn = 1'b0;
      step(3);
   endtask
   task automatic press();
      pressReq = 1'b1;
      step(1);
      pressReq = 1'b0;
      step(4);
   endtask
   task automatic summarize();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {rst_n, powerRestored, firmwareLoaded, uvRuntimeClear, pressReq} = '0;
      faults = '0;
      commands = '0;
      countClear = 1'b1;
      failures = 0;
      n_compared = 0;
      cycles = 0;
      rng = 32'hF9C6;
      step(16);
      rst_n = 1'b1;
      countClear = 1'b0;
      checkBit(leds === '0 && buzzer === 1'b0, 1'b1, "power-up outputs");
      checkBit(uvLampEnable, 1'b0, "power-up uv enable");
      repeat (20) begin
         rng = nextRand(rng);
         commands = rng[4:0];
         step(2);
         checkBit(uvLampEnable, expUv(commands), "uv interlock");
         checkBit(leds.blowerGreen, commands.blowerOn, "green key light");
         checkBit(leds.lightBlue, commands.lightOn, "blue key light");
         checkBit(leds.uvYellow, commands.uvOn, "yellow key light");
      end
      commands = '0;
      step(2);
      $display("commands test done");
      for (int i = 0; i < 3; i++) begin
         rng = nextRand(rng);
         n = (i == 0) ? QUAL - 2 * TICKC : 20 + int'(rng % 360);
         faults = 4'h8;
         step(n);
         faults = '0;
         step(QUAL);
         checkBit(leds.alarmRed | buzzer, 1'b0, "short fault annunciated");
      end
      $display("short fault test done");
      for (int i = 0; i < 2; i++) begin
         faults = (i == 0) ? 4'h8 : 4'h4;
         step(QUAL + 12);
         faults = '0;
         checkBit(leds.alarmRed, 1'b1, "airflow alarm");
         checkBit(leds.barRed === ((i == 0) ? 8'h80 : 8'h01), 1'b1, "bar segment");
         checkBit(buzzer, 1'b1, "buzzer on alarm");
         if (i == 0) begin
            countClear = 1'b1;
            step(1);
            countClear = 1'b0;
            step(STEADY - 40);
            checkCount(buzzCycles, STEADY - 40, "steady tone");
            checkBit(leds.barRed[7], 1'b1, "latched after cause gone");
            step(40);
            countClear = 1'b1;
            step(1);
            countClear = 1'b0;
            step(2 * PERIOD);
            checkCount(buzzCycles, 2 * BEEP, "beep cadence");
         end
         clearAll();
         checkBit(leds.alarmRed, 1'b0, "blower cycle clears alarm");
         checkBit(leds.barRed === 8'h00, 1'b1, "blower cycle clears bar");
      end
      $display("airflow test done");
      faults = 4'h2;
      step(QUAL + 12);
      faults = '0;
      checkBit(leds.alarmRed, 1'b1, "motor alarm");
      blinkCount(1);
      checkBit(ones > 0 && ones < 60, 1'b1, "blower red blink");
      clearAll();
      faults = 4'h1;
      step(QUAL + 12);
      faults = '0;
      checkBit(leds.alarmRed, 1'b1, "uv worn alarm");
      blinkCount(2);
      checkBit(ones > 0 && ones < 60, 1'b1, "uv fast blink");
      uvRuntimeClear = 1'b1;
      step(1);
      uvRuntimeClear = 1'b0;
      step(4);
      checkBit(leds.uvYellow | leds.alarmRed, 1'b0, "run time clear");
      clearAll();
      $display("motor and uv test done");
      powerRestored = 1'b1;
      step(1);
      powerRestored = 1'b0;
      step(4);
      blinkCount(0);
      checkBit(ones > 0 && ones < 60, 1'b1, "power blink");
      press();
      checkBit(leds.alarmRed, 1'b0, "key clears power");
      powerRestored = 1'b1;
      step(1);
      powerRestored = 1'b0;
      rst_n = 1'b0;
      step(2);
      checkBit(leds === '0 && buzzer === 1'b0, 1'b1, "outputs in mid-run reset");
      rst_n = 1'b1;
      blinkCount(0);
      checkCount(ones, 0, "power cycle clears power blink");
      firmwareLoaded = 1'b1;
      step(1);
      firmwareLoaded = 1'b0;
      step(4);
      blinkCount(3);
      checkBit(ones > 0 && ones < 60, 1'b1, "firmware blink");
      press();
      checkBit(leds.barAll === 8'h00, 1'b1, "key clears firmware");
      $display("event test done");
      summarize();
   end
endmodule // test_cabinet_alarm_annunciator

`default_nettype wire
